// ===== core/gport_pkg.sv
// constants for the general port interrupt and control block
// assumes a 32-bit register port with one-cycle read latency
package gport_pkg;
	localparam int data_w = 32;
	localparam int addr_w = 8;
	// register offsets (byte addresses)
	localparam logic [7:0] port_ctrl_off = 8'h78;
	localparam logic [7:0] main_status_off = 8'h28;
	localparam logic [7:0] int_status_off = 8'h80;
	localparam logic [7:0] int_mask_off = 8'h84;
	// field positions in the port register
	localparam int rx_match_bit = 30;
	localparam int pin1_flag_bit = 29;
	localparam int pin0_flag_bit = 28;
	localparam int cwe_bit = 27;
	localparam int rme_bit = 26;
	localparam int pin1_en_bit = 25;
	localparam int pin0_en_bit = 24;
	localparam int sel_lo = 20;
	localparam int data_lo = 16;
	// summary bit in the main status register
	localparam int port_int_bit = 26;
	// reset values
	localparam logic [2:0] enables_rst = 3'h0;
	localparam logic [3:0] sel_rst = 4'h0;
	localparam logic [3:0] dir_rst = 4'h0;
	localparam logic [3:0] pdata_rst = 4'h0;
	localparam logic [2:0] int_mask_rst = 3'h0;
	localparam logic [2:0] flags_rst = 3'h0;
	localparam logic port_int_rst = 1'h0;
	localparam logic [2:0] int_stat_rst = 3'h0;
	localparam logic irq_rst = 1'h0;
endpackage : gport_pkg

// ===== core/pin_sync.sv
// three-stage synchroniser with change detection for one input pin
// assumes the pin is asynchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
	input wire logic mclk_i, // device clock
	input wire logic reset_i, // async reset, active high
	input wire logic pin_i, // raw pin
	output logic level_o, // settled level
	output logic change_o // one-cycle pulse on any edge
);
	logic s1_reg, s2_reg, s3_reg;
	logic s1_next, s2_next, s3_next;

	always_comb
	begin
		s1_next = pin_i;
		s2_next = s1_reg;
		s3_next = s2_reg;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
		end
	end

	assign level_o = s3_reg;
	// either edge counts once stages two and three disagree
	assign change_o = s2_reg ^ s3_reg;
endmodule : pin_sync
`default_nettype wire

// ===== core/general_port_interrupt_control.sv
// general port interrupt flags and control-write logic of the port register
// assumes a plain register port, read data one cycle after the read strobe
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module general_port_interrupt_control
(
	input wire logic mclk_i, // 10 MHz device clock
	input wire logic reset_i, // hardware reset, async, active high
	input wire logic soft_reset_i, // software reset pulse
	input wire logic [gport_pkg::addr_w-1:0] addr_i, // register address
	input wire logic [gport_pkg::data_w-1:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [gport_pkg::data_w-1:0] rdata_o, // read data, cycle after rd_i
	input wire logic rx_match_i, // pulse: packet passed address filter
	input wire logic [1:0] gp_pin_i, // general-purpose input pins 1:0
	output logic [3:0] gp_data_o, // pin output data
	output logic [3:0] gp_dir_o, // pin directions, 1 = output
	output logic [3:0] gp_sel_o, // led/pin selects
	output logic port_int_o, // summary port interrupt level
	output logic irq_o // block interrupt line
);
	import gport_pkg::*;

	// ==========================================
	// pin synchronisers
	logic [1:0] pin_level, pin_change;
	for (genvar g = 0; g < 2; g++)
	begin : g_sync
		pin_sync u_sync
		(
			.mclk_i(mclk_i),
			.reset_i(reset_i),
			.pin_i(gp_pin_i[g]),
			.level_o(pin_level[g]),
			.change_o(pin_change[g])
		);
	end

	// ==========================================
	// helper functions
	function automatic logic hit(input logic [addr_w-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// clear on request, then let fresh events set again: set wins
	function automatic logic [2:0] clear_then_set(
		input logic [2:0] cur,
		input logic [2:0] clr,
		input logic [2:0] set
	);
		clear_then_set = (cur & ~clr) | set;
	endfunction : clear_then_set

	// ==========================================
	// register state
	logic [2:0] flags_reg, flags_next; // {rx_match_flag, pin1, pin0}
	logic [2:0] enables_reg, enables_next; // {rme, pin1_en, pin0_en}
	logic [3:0] sel_reg, sel_next;
	logic [3:0] dir_reg, dir_next;
	logic [3:0] pdata_reg, pdata_next;
	logic port_int_reg, port_int_next;
	logic [2:0] int_stat_reg, int_stat_next; // {summary, rx_match, pin}
	logic [2:0] int_mask_reg, int_mask_next;
	logic irq_reg, irq_next;
	logic [data_w-1:0] rdata_reg, rdata_next;
	logic [2:0] events, gated;
	logic port_rd, port_wr;
	logic status_wr, int_stat_wr, int_mask_wr;
	logic summary_rise;

	// ==========================================
	// register port decode
	always_comb
	begin
		port_rd = rd_i && hit(addr_i, port_ctrl_off);
		port_wr = wr_i && hit(addr_i, port_ctrl_off);
		status_wr = wr_i && hit(addr_i, main_status_off);
		int_stat_wr = wr_i && hit(addr_i, int_status_off);
		int_mask_wr = wr_i && hit(addr_i, int_mask_off);
	end

	// ==========================================
	// event flags
	always_comb
	begin
		events[2] = rx_match_i;
		// only pins configured as inputs may flag
		events[1] = pin_change[1] && !dir_reg[1];
		events[0] = pin_change[0] && !dir_reg[0];
		// read clears, a same-cycle event still sets
		flags_next = clear_then_set(flags_reg, {3{port_rd}}, events);
		// per-flag enables gate the summary
		gated = flags_reg & enables_reg;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			flags_reg <= flags_rst;
		end
		else
		begin
			flags_reg <= flags_next;
		end
	end

	// ==========================================
	// control fields and pin data
	always_comb
	begin
		enables_next = enables_reg;
		sel_next = sel_reg;
		dir_next = dir_reg;
		pdata_next = pdata_reg;
		if (port_wr)
		begin
			pdata_next = wdata_i[data_lo +: 4];
			if (wdata_i[cwe_bit])
			begin
				enables_next = wdata_i[pin0_en_bit +: 3];
				sel_next = wdata_i[sel_lo +: 4];
				dir_next = wdata_i[data_lo +: 4];
			end
		end
		// software reset clears only the enables, winning over a same-cycle write to them
		if (soft_reset_i)
		begin
			enables_next = enables_rst;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			enables_reg <= enables_rst;
			sel_reg <= sel_rst;
			dir_reg <= dir_rst;
			pdata_reg <= pdata_rst;
		end
		else
		begin
			enables_reg <= enables_next;
			sel_reg <= sel_next;
			dir_reg <= dir_next;
			pdata_reg <= pdata_next;
		end
	end

	// ==========================================
	// summary port interrupt
	always_comb
	begin
		// write-one clears the summary only, flags stay
		port_int_next = port_int_reg;
		if (status_wr && wdata_i[port_int_bit])
		begin
			port_int_next = 1'h0;
		end
		// a gated flag still set re-sets it
		if (|gated)
		begin
			port_int_next = 1'h1;
		end
		summary_rise = port_int_next && !port_int_reg;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			port_int_reg <= port_int_rst;
		end
		else
		begin
			port_int_reg <= port_int_next;
		end
	end

	// ==========================================
	// block interrupt status, write one to clear
	always_comb
	begin
		int_stat_next = clear_then_set(int_stat_reg, int_stat_wr ? wdata_i[2:0] : 3'h0,
			{summary_rise, events[2], |events[1:0]});
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			int_stat_reg <= int_stat_rst;
		end
		else
		begin
			int_stat_reg <= int_stat_next;
		end
	end

	// ==========================================
	// block interrupt mask
	always_comb
	begin
		int_mask_next = int_mask_reg;
		if (int_mask_wr)
		begin
			int_mask_next = wdata_i[2:0];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			int_mask_reg <= int_mask_rst;
		end
		else
		begin
			int_mask_reg <= int_mask_next;
		end
	end

	// ==========================================
	// level interrupt line
	always_comb
	begin
		irq_next = |(int_stat_next & int_mask_next);
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			irq_reg <= irq_rst;
		end
		else
		begin
			irq_reg <= irq_next;
		end
	end

	// ==========================================
	// read data, one cycle after the strobe
	always_comb
	begin
		rdata_next = '0;
		if (rd_i)
		begin
			case (addr_i)
				port_ctrl_off:
				begin
					rdata_next[rx_match_bit] = flags_reg[2];
					rdata_next[pin1_flag_bit] = flags_reg[1];
					rdata_next[pin0_flag_bit] = flags_reg[0];
					rdata_next[pin0_en_bit +: 3] = enables_reg;
					rdata_next[sel_lo +: 4] = sel_reg;
					rdata_next[data_lo +: 4] = {pdata_reg[3:2], pin_level};
				end
				main_status_off:
				begin
					rdata_next[port_int_bit] = port_int_reg;
				end
				int_status_off:
				begin
					rdata_next[2:0] = int_stat_reg;
				end
				int_mask_off:
				begin
					rdata_next[2:0] = int_mask_reg;
				end
				default:
				begin
					rdata_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rdata_reg <= '0;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================
	// outputs, each straight from a flip-flop
	assign rdata_o = rdata_reg;
	assign gp_data_o = pdata_reg;
	assign gp_dir_o = dir_reg;
	assign gp_sel_o = sel_reg;
	assign port_int_o = port_int_reg;
	assign irq_o = irq_reg;
endmodule : general_port_interrupt_control
`default_nettype wire

// ===== tb/gpic_assertions.sv
// checker of port flags, enables and control writes
// assumes it is bound onto the port block
`timescale 1ns/1ps
`default_nettype none
module gpic_assertions
(
	input wire logic mclk_i, // clk
	input wire logic reset_i, // rst
	input wire logic soft_reset_i, // soft rst
	input wire logic [7:0] addr_i, // addr
	input wire logic [31:0] wdata_i, // wdata
	input wire logic wr_i, // write
	input wire logic rd_i, // read
	input wire logic [31:0] rdata_o, // rdata
	input wire logic rx_match_i, // match
	input wire logic [3:0] gp_data_o, // data
	input wire logic [3:0] gp_dir_o, // dirs
	input wire logic [3:0] gp_sel_o, // selects
	input wire logic port_int_o // summary
);
	import gport_pkg::*;
	logic pw, pr;
	assign pw = wr_i && addr_i == port_ctrl_off;
	assign pr = rd_i && addr_i == port_ctrl_off;
	// ========
	// properties
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	sequence rx_read;
		rx_match_i ##1 pr;
	endsequence
	sequence rx_ms_read;
		rx_match_i ##1 wr_i && addr_i == main_status_off ##1 pr;
	endsequence
	sequence read_twice;
		pr && !rx_match_i ##1 !rx_match_i ##1 pr;
	endsequence
	a_rx_sets: assert property (rx_read |=> rdata_o[rx_match_bit])
		else $error("flag not set");
	a_ms_keeps: assert property (rx_ms_read |=> rdata_o[rx_match_bit])
		else $error("flag lost");
	a_read_clears: assert property (read_twice |=> !rdata_o[rx_match_bit])
		else $error("flag kept");
	a_rx_summary: assert property (pr |=> !(rdata_o[30] && rdata_o[26]) || port_int_o)
		else $error("no match summary");
	a_pin_summary: assert property (pr |=> port_int_o ||
		!(rdata_o[29] && rdata_o[25] || rdata_o[28] && rdata_o[24]))
		else $error("no pin summary");
	a_cwe_write: assert property (pw && wdata_i[cwe_bit] |=>
		{gp_sel_o, gp_dir_o} == $past(wdata_i[23:16]))
		else $error("control lost");
	a_data_only: assert property (pw && !wdata_i[cwe_bit] |=>
		$stable({gp_sel_o, gp_dir_o}) && gp_data_o == $past(wdata_i[19:16]))
		else $error("data write wrong");
	a_soft_clear: assert property (soft_reset_i && !wr_i ##1 pr |=> !rdata_o[26:24])
		else $error("enables kept");
endmodule : gpic_assertions
bind general_port_interrupt_control gpic_assertions i_chk (.*);
`default_nettype wire

// ===== tb/general_port_interrupt_control_test.sv
// bench for the port interrupt and control block
// assumes gport_pkg and the block are compiled first
`timescale 1ns/1ps
`default_nettype none
module general_port_interrupt_control_test;
	import gport_pkg::*;
	logic mclk_i = 1'h0, reset_i = 1'h1, soft_reset_i = 1'h0, port_int_o, irq_o;
	logic wr_i = 1'h0, rd_i = 1'h0, rx_match_i = 1'h0;
	logic [7:0] addr_i = 8'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o, r;
	logic [1:0] gp_pin_i = 2'h0;
	logic [3:0] gp_data_o, gp_dir_o, gp_sel_o;
	logic [43:0] rows [3] = '{{32'h0b5a0000, 12'h5aa}, {32'h00030000, 12'h5a3},
		{32'h08000000, 12'h0}};
	int n_fail = 0, tests_run = 0, cyc = 0;
	general_port_interrupt_control i_dut (.*);
	// ========
	// drivers and checks
	initial forever #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, q, x, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= w;
		rd_i <= q;
		rx_match_i <= x;
		soft_reset_i <= 1'h0;
		addr_i <= a;
		wdata_i <= d;
	endtask : bus
	task automatic idle(input int n);
		repeat (n) bus(1'h0, 1'h0, 1'h0, 8'h0, 32'h0);
		#1;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, 1'h0, 1'h0, a, d);
		idle(1);
	endtask : wr
	task automatic rp(input logic [31:0] e, input logic [7:0] a = port_ctrl_off);
		bus(1'h0, 1'h1, 1'h0, a, 32'h0);
		idle(1);
		r = rdata_o;
		chk("port", e, 32'({r[30:28], r[26:24]}));
	endtask : rp
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (6) @(posedge mclk_i);
		reset_i <= 1'h0;
		foreach (rows[i])
		begin
			wr(port_ctrl_off, rows[i][43:12]);
			chk("ctrl", 32'(rows[i][11:0]), 32'({gp_sel_o, gp_dir_o, gp_data_o}));
		end
		wr(port_ctrl_off, 32'h0f5a0000);
		@(posedge mclk_i) reset_i <= 1'h1;
		@(posedge mclk_i) reset_i <= 1'h0;
		rp(32'h0);
		$display("test rows and reset done");
		wr(port_ctrl_off, 32'h0c000000);
		bus(1'h0, 1'h0, 1'h1, 8'h0, 32'h0);
		bus(1'h1, 1'h0, 1'h0, main_status_off, 32'h04000000);
		rp(32'h24);
		chk("summary", 32'h1, 32'(port_int_o));
		chk("irq masked", 32'h0, 32'(irq_o));
		wr(int_mask_off, 32'h7);
		idle(1);
		chk("irq", 32'h1, 32'(irq_o));
		rp(32'h04);
		wr(main_status_off, 32'h04000000);
		wr(int_status_off, 32'h7);
		idle(2);
		chk("irq clear", 32'h0, 32'(irq_o));
		wr(port_ctrl_off, 32'h08000000);
		bus(1'h0, 1'h0, 1'h1, 8'h0, 32'h0);
		idle(3);
		chk("blocked", 32'h0, 32'(port_int_o));
		rp(32'h20);
		$display("test match done");
		wr(port_ctrl_off, 32'h0b010000);
		@(posedge mclk_i) gp_pin_i <= 2'h3;
		idle(6);
		rp(32'h13);
		chk("pin summary", 32'h1, 32'(port_int_o));
		wr(port_ctrl_off, 32'h0a000000);
		wr(main_status_off, 32'h04000000);
		@(posedge mclk_i) gp_pin_i <= 2'h2;
		idle(6);
		chk("pin0 gated", 32'h0, 32'(port_int_o));
		rp(32'h0a);
		@(posedge mclk_i) soft_reset_i <= 1'h1;
		rp(32'h0);
		rp(32'h0);
		rp(32'h0, 8'h40);
		$display("test pins done");
		report_and_stop();
	end
endmodule : general_port_interrupt_control_test
`default_nettype wire
